// File: verilog/coherency_unit_defines.vh
// Purpose: Constants shared by the coherency unit configuration register bank.
// Assumes: 32-bit APB data, byte addresses, word-aligned registers.
// Notes:   Offsets are local to the register bank window.
`ifndef COHERENCY_UNIT_DEFINES_VH
`define COHERENCY_UNIT_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_TAG_INVALIDATE_WAYS  12'h00c
`define OFS_FILTER_RANGE_START   12'h040
`define OFS_FILTER_RANGE_END     12'h044
`define OFS_SECURE_ACCESS_GATE   12'h050
`define OFS_NONSECURE_ACCESS_GATE 12'h054

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define WAYS_PER_CPU             4
`define WAY_FIELD_MSB            15
`define FILTER_MSB               31
`define FILTER_LSB               20
`define FILTER_W                 12
`define GATE_MSB                 3
`define PROT_NONSECURE_BIT       1

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define GATE_SECURE_RESET        4'hf
`define GATE_NONSECURE_RESET     4'h0
`define FILTER_RESET             12'h000
`define ZERO_WORD                32'h0000_0000
`define STRAP_SYNC_CYCLES        2'h2
`define SYNC_CNT_RESET           2'h0

`endif

// File: verilog/coherency_unit_config_regs.v
// Purpose: Configuration register bank of the coherency unit: tag invalidate,
//          address filter bounds and the two per-processor access gates.
// Assumes: APB slave; CPU_ID and PPROT come with the request on SYS_CLK.
// Notes:   Straps are asynchronous pins and are synchronised before loading.
`timescale 1ns/100ps
`include "coherency_unit_defines.vh"

module coherency_unit_config_regs #(
    parameter NUM_CPUS         = 4,
    parameter NUM_MASTER_PORTS = 2
) (
    // Clock and reset
    input  wire        SYS_CLK,
    input  wire        RESET,
    // APB slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    input  wire [2:0]  PPROT,
    input  wire [1:0]  CPU_ID,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    // Strap pins
    input  wire [11:0] FILTER_LOW_STRAP,
    input  wire [11:0] FILTER_HIGH_STRAP,
    // Filter use
    input  wire        FILTER_ENABLE,
    input  wire [31:0] PROBE_ADDR,
    output reg         PROBE_TO_PORT1,
    output reg  [11:0] FILTER_START,
    output reg  [11:0] FILTER_END,
    // Tag invalidate command
    output reg         INVALIDATE_VALID,
    output reg  [15:0] INVALIDATE_WAYS
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Way bits of processors that are not present are forced to zero.
    function [15:0] present_ways;
        input [15:0] ways;
        integer      cpu;
        begin
            present_ways = 16'h0000;
            for (cpu = 0; cpu < 4; cpu = cpu + 1) begin
                if (cpu < NUM_CPUS) begin
                    present_ways[cpu*`WAYS_PER_CPU +: `WAYS_PER_CPU] =
                        ways[cpu*`WAYS_PER_CPU +: `WAYS_PER_CPU];
                end
            end
        end
    endfunction

    function [31:0] filter_word;
        input [11:0] bound;
        begin
            filter_word = {bound, 20'h00000};
        end
    endfunction

    localparam HAS_FILTER = (NUM_MASTER_PORTS > 1);

    // ------------------------------------------------------------------------
    // Strap synchronisers and reset-exit load
    // ------------------------------------------------------------------------
    reg [11:0] low_meta_q;
    reg [11:0] low_sync_q;
    reg [11:0] high_meta_q;
    reg [11:0] high_sync_q;
    reg [1:0]  sync_cnt_q;
    reg        load_done_q;
    wire       strap_load;

    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            low_meta_q  <= `FILTER_RESET;
            low_sync_q  <= `FILTER_RESET;
            high_meta_q <= `FILTER_RESET;
            high_sync_q <= `FILTER_RESET;
            sync_cnt_q  <= `SYNC_CNT_RESET;
            load_done_q <= 1'b0;
        end else begin
            low_meta_q  <= FILTER_LOW_STRAP;
            low_sync_q  <= low_meta_q;
            high_meta_q <= FILTER_HIGH_STRAP;
            high_sync_q <= high_meta_q;
            if (sync_cnt_q != `STRAP_SYNC_CYCLES) begin
                sync_cnt_q <= sync_cnt_q + 2'h1;
            end
            if (strap_load) begin
                load_done_q <= 1'b1;
            end
        end
    end

    // Loading waits until the synchroniser holds the pin value, not reset zeros.
    assign strap_load = !load_done_q && (sync_cnt_q == `STRAP_SYNC_CYCLES);

    // ------------------------------------------------------------------------
    // APB decode and access gating
    // ------------------------------------------------------------------------
    reg  [3:0]  sgate_q;
    reg  [3:0]  nsgate_q;
    reg  [11:0] start_q;
    reg  [11:0] end_q;
    wire        nonsecure;
    wire        sel_inval;
    wire        sel_start;
    wire        sel_end;
    wire        sel_sgate;
    wire        sel_nsgate;
    wire        mapped;
    wire        granted;
    wire        commit;
    wire        wr_ok;

    assign nonsecure  = PPROT[`PROT_NONSECURE_BIT];
    assign sel_inval  = (PADDR == `OFS_TAG_INVALIDATE_WAYS);
    assign sel_start  = (PADDR == `OFS_FILTER_RANGE_START);
    assign sel_end    = (PADDR == `OFS_FILTER_RANGE_END);
    assign sel_sgate  = (PADDR == `OFS_SECURE_ACCESS_GATE);
    assign sel_nsgate = (PADDR == `OFS_NONSECURE_ACCESS_GATE);
    assign mapped     = sel_inval | sel_start | sel_end | sel_sgate | sel_nsgate;

    // Secure writes need the processor's secure gate bit; non-secure writes
    // need both gate bits, so a zeroed secure gate locks out everyone.
    assign granted = sgate_q[CPU_ID] && (!nonsecure || nsgate_q[CPU_ID]);

    // The write lands on the edge that samples PREADY high.
    assign commit = PSEL && PENABLE && PREADY;
    assign wr_ok  = commit && PWRITE && granted;

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            sgate_q  <= `GATE_SECURE_RESET;
            nsgate_q <= `GATE_NONSECURE_RESET;
            start_q  <= `FILTER_RESET;
            end_q    <= `FILTER_RESET;
        end else begin
            if (wr_ok && sel_sgate) begin
                sgate_q <= PWDATA[`GATE_MSB:0];
            end
            // The non-secure gate is a secure-only register.
            if (wr_ok && sel_nsgate && !nonsecure) begin
                nsgate_q <= PWDATA[`GATE_MSB:0];
            end
            if (strap_load) begin
                start_q <= low_sync_q;
                end_q   <= high_sync_q;
            end else if (HAS_FILTER) begin
                if (wr_ok && sel_start) begin
                    start_q <= PWDATA[`FILTER_MSB:`FILTER_LSB];
                end
                if (wr_ok && sel_end) begin
                    end_q <= PWDATA[`FILTER_MSB:`FILTER_LSB];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Tag invalidate command
    // ------------------------------------------------------------------------
    // Tag invalidation is a Secure-state operation only.
    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            INVALIDATE_VALID <= 1'b0;
            INVALIDATE_WAYS  <= 16'h0000;
        end else begin
            INVALIDATE_VALID <= wr_ok && sel_inval && !nonsecure;
            if (wr_ok && sel_inval && !nonsecure) begin
                // One bit per way; absent processors see no invalidation.
                INVALIDATE_WAYS <= present_ways(PWDATA[`WAY_FIELD_MSB:0]);
            end else begin
                INVALIDATE_WAYS <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------------------
    reg [31:0] rdata_d;

    always @* begin
        rdata_d = `ZERO_WORD;
        if (sel_start && HAS_FILTER) begin
            rdata_d = filter_word(start_q);
        end else if (sel_end && HAS_FILTER) begin
            rdata_d = filter_word(end_q);
        end else if (sel_sgate) begin
            rdata_d = {28'h0000000, sgate_q};
        end else if (sel_nsgate) begin
            rdata_d = {28'h0000000, nsgate_q};
        end
        // The tag invalidate register falls through to zero.
    end

    // Every transfer takes one wait state so that PREADY comes from a flop.
    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= `ZERO_WORD;
        end else begin
            PREADY  <= PSEL && PENABLE && !PREADY;
            PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
            if (PSEL && PENABLE && !PREADY && !PWRITE) begin
                PRDATA <= rdata_d;
            end else begin
                PRDATA <= `ZERO_WORD;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Filter outputs
    // ------------------------------------------------------------------------
    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            FILTER_START   <= `FILTER_RESET;
            FILTER_END     <= `FILTER_RESET;
            PROBE_TO_PORT1 <= 1'b0;
        end else begin
            FILTER_START   <= HAS_FILTER ? start_q : `FILTER_RESET;
            FILTER_END     <= HAS_FILTER ? end_q : `FILTER_RESET;
            // Megabyte compare with an inclusive top so the last megabyte fits.
            PROBE_TO_PORT1 <= HAS_FILTER && FILTER_ENABLE &&
                              (PROBE_ADDR[`FILTER_MSB:`FILTER_LSB] >= start_q) &&
                              (PROBE_ADDR[`FILTER_MSB:`FILTER_LSB] <= end_q);
        end
    end

endmodule // coherency_unit_config_regs

// File: verilog/unused_placeholder_none.v
`timescale 1ns/100ps
// Purpose: none.
// Assumes: none.
// Notes:   intentionally empty.

// File: verif/cfg_regs_asserts.sv
// Purpose: Port-level checks on the configuration register bank.
// Assumes: One SYS_CLK domain, RESET active high.
// Notes:   Bound to every instance of the bank.
`timescale 1ns/100ps
`include "coherency_unit_defines.vh"
module cfg_regs_asserts #(
    parameter NUM_CPUS         = 4,
    parameter NUM_MASTER_PORTS = 2
) (
    input wire        SYS_CLK,
    input wire        RESET,
    input wire        PSEL,
    input wire        PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [2:0]  PPROT,
    input wire [31:0] PRDATA,
    input wire        PREADY,
    input wire        PSLVERR,
    input wire        FILTER_ENABLE,
    input wire [31:0] PROBE_ADDR,
    input wire        PROBE_TO_PORT1,
    input wire [11:0] FILTER_START,
    input wire [11:0] FILTER_END,
    input wire        INVALIDATE_VALID,
    input wire [15:0] INVALIDATE_WAYS
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    wire        rd_done = PSEL && PREADY && !PWRITE;
    wire        inv_at  = PADDR == `OFS_TAG_INVALIDATE_WAYS;
    wire        st_at   = PADDR == `OFS_FILTER_RANGE_START;
    wire        en_at   = PADDR == `OFS_FILTER_RANGE_END;
    // Way fields of absent processors never reach the tag RAMs.
    wire [15:0] live    = 16'(16'hffff >> (4 * (4 - NUM_CPUS)));

    a_inval_read_zero: assert property (rd_done && inv_at |-> PRDATA == 32'h0)
        else $error("invalidate register read not zero");
    a_inval_cause: assert property (INVALIDATE_VALID |-> $past(PSEL && PREADY && PWRITE && inv_at && !PPROT[1]))
        else $error("invalidate pulse without secure write");
    a_inval_ways: assert property (INVALIDATE_VALID |-> INVALIDATE_WAYS == ($past(PWDATA[15:0]) & live))
        else $error("invalidate ways differ from written fields");
    a_ways_idle: assert property (!INVALIDATE_VALID |-> INVALIDATE_WAYS == 16'h0000)
        else $error("ways shown without pulse");
    a_filter_low_zero: assert property (rd_done && (st_at || en_at) |-> PRDATA[19:0] == 20'h00000)
        else $error("filter low bits not zero");
    a_start_readback: assert property (rd_done && st_at |-> PRDATA[31:20] == FILTER_START)
        else $error("start read differs from bound");
    a_end_readback: assert property (rd_done && en_at |-> PRDATA[31:20] == FILTER_END)
        else $error("end read differs from bound");
    a_probe_steer: assert property (!$past(RESET) |-> PROBE_TO_PORT1 == ($past(FILTER_ENABLE) &&
        $past(PROBE_ADDR[31:20]) >= FILTER_START && $past(PROBE_ADDR[31:20]) <= FILTER_END && NUM_MASTER_PORTS == 2))
        else $error("port one steering wrong");
    c_inval: cover property (INVALIDATE_VALID);
    c_probe: cover property (PROBE_TO_PORT1);
    c_slverr: cover property (PREADY && PSLVERR);
endmodule // cfg_regs_asserts

bind coherency_unit_config_regs cfg_regs_asserts #(.NUM_CPUS(NUM_CPUS), .NUM_MASTER_PORTS(NUM_MASTER_PORTS)) u_chk (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PPROT(PPROT), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FILTER_ENABLE(FILTER_ENABLE),
    .PROBE_ADDR(PROBE_ADDR), .PROBE_TO_PORT1(PROBE_TO_PORT1), .FILTER_START(FILTER_START),
    .FILTER_END(FILTER_END), .INVALIDATE_VALID(INVALIDATE_VALID), .INVALIDATE_WAYS(INVALIDATE_WAYS));

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: Four processors, two master ports.
// Notes:   The lockout runs last, since only reset undoes it.
`timescale 1ns/100ps
`include "coherency_unit_defines.vh"
module tb_top;
    localparam logic [11:0] a_inv = `OFS_TAG_INVALIDATE_WAYS;
    localparam logic [11:0] a_st  = `OFS_FILTER_RANGE_START;
    localparam logic [11:0] a_en  = `OFS_FILTER_RANGE_END;
    localparam logic [11:0] a_sg  = `OFS_SECURE_ACCESS_GATE;
    localparam logic [11:0] a_ns  = `OFS_NONSECURE_ACCESS_GATE;
    logic        sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, ns_q = 0, f_en = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, probe_addr = 0, rd;
    logic [1:0]  cpu_id = 0;
    logic        er;
    wire  [31:0] prdata;
    wire         pready, pslverr, to_p1, inv_v;
    wire  [15:0] inv_w;
    int          err_count = 0, checks_done = 0;

    coherency_unit_config_regs i_coherency_unit_config_regs (.SYS_CLK(sys_clk), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PPROT({1'b0, ns_q, 1'b0}),
        .CPU_ID(cpu_id), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FILTER_LOW_STRAP(12'h4a5),
        .FILTER_HIGH_STRAP(12'h9c3), .FILTER_ENABLE(f_en), .PROBE_ADDR(probe_addr), .PROBE_TO_PORT1(to_p1),
        .FILTER_START(), .FILTER_END(), .INVALIDATE_VALID(inv_v), .INVALIDATE_WAYS(inv_w));

    initial forever #2 sys_clk = ~sys_clk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [1:0] id, input logic ns);
        int n;
        @(posedge sys_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        cpu_id <= id;
        ns_q <= ns;
        @(posedge sys_clk);
        penable <= 1;
        n = 0;
        // Look between edges, so that the answer is read while it stands.
        @(negedge sys_clk);
        while (pready !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        rd = prdata;
        er = pslverr;
        @(posedge sys_clk);
        psel <= 0;
        penable <= 0;
        if (n >= 20) chk("pready", 1, 0);
    endtask

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 0, 0, 0);
        chk(what, exp, rd);
    endtask

    task automatic probe(input logic [31:0] a, input logic en, input logic exp);
        @(posedge sys_clk);
        probe_addr <= a;
        f_en <= en;
        repeat (2) @(posedge sys_clk);
        chk("probe", {31'h0, exp}, {31'h0, to_p1});
    endtask

    // The pulse shows in the cycle after the completing edge, so look mid-cycle.
    task automatic inv_chk(input string what, input logic [31:0] exp);
        @(negedge sys_clk);
        chk(what, exp, {15'h0, inv_v, inv_w});
    endtask

    task automatic t_reset_values;
        rdchk("start", a_st, 32'h4a50_0000);
        rdchk("end", a_en, 32'h9c30_0000);
        rdchk("sgate", a_sg, 32'h0000_000f);
        rdchk("nsgate", a_ns, 32'h0);
    endtask

    task automatic t_filter;
        apb(1, a_st, 32'h1234_5678, 0, 0);
        rdchk("start", a_st, 32'h1230_0000);
        apb(1, a_en, 32'hffff_ffff, 0, 0);
        rdchk("end", a_en, 32'hfff0_0000);
        probe(32'hfff8_0000, 1, 1);
        probe(32'h1230_0000, 1, 1);
        probe(32'h122f_ffff, 1, 0);
        probe(32'hfff8_0000, 0, 0);
    endtask

    task automatic t_invalidate;
        apb(1, a_inv, 32'hffff_a5c3, 0, 0);
        inv_chk("ways", 32'h0001_a5c3);
        rdchk("inval", a_inv, 32'h0);
        apb(1, a_inv, 32'h0000_000f, 0, 1);
        inv_chk("ways_ns", 32'h0);
        apb(0, 12'h7f0, 0, 0, 0);
        chk("slverr", 1, {31'h0, er});
    endtask

    task automatic t_gates;
        apb(1, a_st, 32'h2000_0000, 1, 1);
        rdchk("start_ns", a_st, 32'h1230_0000);
        apb(1, a_ns, 32'hffff_fff2, 0, 0);
        rdchk("nsgate", a_ns, 32'h2);
        apb(1, a_st, 32'h2000_0000, 1, 1);
        rdchk("start_ns1", a_st, 32'h2000_0000);
        apb(1, a_st, 32'h3000_0000, 2, 1);
        rdchk("start_ns2", a_st, 32'h2000_0000);
        apb(1, a_sg, 32'h0000_000d, 0, 0);
        apb(1, a_st, 32'h4000_0000, 1, 0);
        rdchk("start_s1", a_st, 32'h2000_0000);
        apb(1, a_sg, 32'h0, 0, 0);
        rdchk("sgate0", a_sg, 32'h0);
        apb(1, a_st, 32'h6000_0000, 0, 0);
        rdchk("start_lock", a_st, 32'h2000_0000);
        apb(1, a_inv, 32'h0000_000f, 0, 0);
        inv_chk("ways_lock", 32'h0);
    endtask

    task automatic wrap_up;
        if (err_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // About 28 transfers of 4 cycles each; the margin covers a stuck handshake.
    initial begin
        repeat (3000) @(posedge sys_clk);
        chk("watchdog", 0, 1);
        wrap_up;
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 0;
        repeat (4) @(posedge sys_clk);
        t_reset_values;
        t_filter;
        t_invalidate;
        t_gates;
        wrap_up;
    end
endmodule // tb_top
